// file: rtl/dcc_cfg.svh
// Purpose: Offsets, field values, reset values and codes of the
//          transfer counter and configuration block
// Assumes: 32-bit APB register bus, byte lanes on pstrb
// Notes:   Included by the design file and the bench
`ifndef DCC_CFG_SVH
`define DCC_CFG_SVH
// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define DCC_OFS_CMD      12'h030
`define DCC_OFS_COUNT    12'h034
`define DCC_OFS_CONFIG   12'h038
`define DCC_OFS_STATUS   12'h040
`define DCC_OFS_CONTROL  12'h044
// ----------------------------------------------------------------
// Reset and read values
// ----------------------------------------------------------------
`define DCC_COUNT_RST    32'h0000_0000
`define DCC_CONFIG_RST   16'h0001
`define DCC_CMD_READ     32'h0000_00FF
`define DCC_MSB_LANE     2
// ----------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------
`define DCC_CMD_GENERIC_DMA_RD  8'h00
`define DCC_CMD_GENERIC_DMA_WR  8'h01
`define DCC_CMD_UDMA_RD  8'h02
`define DCC_CMD_UDMA_WR  8'h03
`define DCC_CMD_PIO_RD   8'h04
`define DCC_CMD_PIO_WR   8'h05
`define DCC_CMD_MDMA_RD  8'h06
`define DCC_CMD_MDMA_WR  8'h07
`define DCC_CMD_RESET    8'h11
// ----------------------------------------------------------------
// Field values
// ----------------------------------------------------------------
`define DCC_UDMA_MODE3   2'h3
`define DCC_PIO_MAX      3'h4
`define DCC_BUF_FULL     2'h2
`endif

// file: rtl/dcc_pkg.sv
// Purpose: Types of the transfer counter and configuration block
// Assumes: Constants come from dcc_cfg.svh
// Notes:   Configuration word layout and state encoding
package dcc_pkg;
    // ----------------------------------------------------------------
    // Configuration word, bit 15 down to bit 0
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       rsv15;                  // Reserved, stored
        logic       skip_ready;             // Ignore ready pin, UDMA
        logic       ata_select;             // ATA versus generic core
        logic [1:0] ultra_multiword_timing; // UDMA/MDMA timing mode
        logic [2:0] programmed_io_timing;   // PIO timing mode
        logic       counter_disable;        // Counter off, slave only
        logic [2:0] burst;                  // Stored, not interpreted
        logic [1:0] strobe_mode;            // Stored, not interpreted
        logic       rsv1;                   // Reserved, stored
        logic       width;                  // Stored, not interpreted
    } dcc_config_t;

    // ----------------------------------------------------------------
    // Status word, low bits
    // ----------------------------------------------------------------
    typedef struct packed {
        logic dir_in;     // Active transfer moves data inward
        logic eot_ended;  // Last transfer closed by end pin
        logic refused;    // A command refused, sticky until cleared
        logic done;       // Transfer finished
        logic busy;       // Transfer running
    } dcc_status_t;

    // One-hot engine states
    typedef enum logic [1:0] {
        DCC_IDLE = 2'b01,
        DCC_RUN  = 2'b10
    } dcc_state_t;
endpackage : dcc_pkg

// file: rtl/dcc_top.sv
// Purpose: Transfer byte counter and configuration of the DMA engine
// Assumes: APB slave, zero wait states; pins synchronised here
// Notes:   Byte stream passes a two-entry buffer, counted on entry
//
// Contract
// - Four-byte counter, reads remaining bytes
// - Counter governs PIO, UDMA, MDMA, generic commands
// - Counter loads only on high byte write
// - Disable bit works in slave mode only
// - End pin closes inward transfer with counter off, validates packet
// - End pin ignored for outward transfers
// - Skip ready bit ignores ready pin, UDMA
// - ATA select one means ATA/MDMA core
// - ATA select zero means generic core
// - Timing values zero to two: modes 0-2
// - Timing value three: UDMA mode 3 only
// - PIO modes 0-4; values 5-7 reserved
`include "dcc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module dcc_top
    import dcc_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RSTN,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Pins from the external party
    input  wire logic        END_OF_TRANSFER_IN,
    input  wire logic        IORDY,
    // Byte source
    input  wire logic        S_VALID,
    input  wire logic [7:0]  S_DATA,
    output logic             S_READY,
    // Byte sink
    output logic             M_VALID,
    output logic      [7:0]  M_DATA,
    input  wire logic        M_READY,
    // Mode and event outputs
    output logic             VALIDATE_PKT,
    output logic             ATA_SELECT,
    output logic      [1:0]  ULTRA_TIMING,
    output logic      [2:0]  PIO_TIMING,
    output logic             STROBE_REG_EN
);
    // ----------------------------------------------------------------
    // Decode helper
    // ----------------------------------------------------------------
    // Register hit test on the word address
    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a[11:2] == o[11:2]);
    endfunction : hit

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    dcc_state_t  state,      next_state;      // Engine state
    logic [31:0] remain,     next_remain;     // Remaining byte count
    logic [23:0] stage,      next_stage;      // Low bytes awaiting load
    dcc_config_t config_w,   next_config_w;   // Configuration word
    dcc_status_t status,     next_status;     // Status flags
    logic        master,     next_master;     // Master handshake mode
    logic [7:0]  cmd,        next_cmd;        // Active command
    logic        validate,   next_validate;   // Packet validate pulse
    logic [7:0]  buf_mem [2];                 // Two-entry buffer
    logic [7:0]  next_mem [2];                // Buffer next contents
    logic        wr_ptr,     next_wr_ptr;     // Buffer write slot
    logic        rd_ptr,     next_rd_ptr;     // Buffer read slot
    logic [1:0]  fill,       next_fill;       // Buffer occupancy
    logic [1:0]  eot_sync,   next_eot_sync;   // End pin synchroniser
    logic [1:0]  rdy_sync,   next_rdy_sync;   // Ready pin synchroniser
    // ----------------------------------------------------------------
    // Combinational terms
    // ----------------------------------------------------------------
    logic        wr_acc;     // APB write access
    logic        mapped;     // Address is mapped
    logic        cnt_en;     // Counter active
    logic        is_udma;    // Active command is UDMA
    logic        ready_ok;   // Ready pin allows transfer
    logic        s_fire;     // Byte enters buffer
    logic        m_fire;     // Byte leaves buffer
    logic        eot_close;  // End pin closes transfer
    logic        cmd_wr;     // Command register written
    logic        cmd_ok;     // Written command accepted
    logic        cmd_xfer;   // Written command is a transfer
    logic [31:0] load_val;   // Full count on high byte write

    // Bus decode, zero wait states
    always_comb
    begin
        mapped  = hit(PADDR, `DCC_OFS_CMD) || hit(PADDR, `DCC_OFS_COUNT) ||
                  hit(PADDR, `DCC_OFS_CONFIG) ||
                  hit(PADDR, `DCC_OFS_STATUS) ||
                  hit(PADDR, `DCC_OFS_CONTROL);
        wr_acc  = PSEL && PENABLE && PWRITE && mapped;
        PREADY  = 1'b1;
        PSLVERR = PSEL && PENABLE && !mapped;
    end

    // Read mux, unused upper bits read zero
    always_comb
    begin
        PRDATA = 32'h0000_0000;
        if (hit(PADDR, `DCC_OFS_CMD))
            PRDATA = `DCC_CMD_READ;
        else if (hit(PADDR, `DCC_OFS_COUNT))
            PRDATA = remain;
        else if (hit(PADDR, `DCC_OFS_CONFIG))
            PRDATA = {16'h0000, config_w};
        else if (hit(PADDR, `DCC_OFS_STATUS))
            PRDATA = {27'h0000000, status};
        else if (hit(PADDR, `DCC_OFS_CONTROL))
            PRDATA = {31'h00000000, master};
    end

    // Transfer gating and command checks
    always_comb
    begin
        // Disable bit honoured only in slave mode
        cnt_en   = master || !config_w.counter_disable;
        is_udma  = (cmd == `DCC_CMD_UDMA_RD) || (cmd == `DCC_CMD_UDMA_WR);
        // Ready pin skipped only for UDMA commands
        ready_ok = rdy_sync[1] || (is_udma && config_w.skip_ready);
        // Stall at zero count while counting, or at full buffer
        S_READY  = (state == DCC_RUN) && (fill != `DCC_BUF_FULL) &&
                   ready_ok && (!cnt_en || remain != 32'h0000_0000);
        s_fire   = S_VALID && S_READY;
        M_VALID  = (fill != 2'h0);
        M_DATA   = buf_mem[rd_ptr];
        m_fire   = M_VALID && M_READY;
        // End pin counts only inward with counter off
        eot_close = (state == DCC_RUN) && !cnt_en && status.dir_in &&
                    eot_sync[1];
        cmd_wr   = wr_acc && hit(PADDR, `DCC_OFS_CMD) && PSTRB[0];
        cmd_xfer = (PWDATA[7:0] <= `DCC_CMD_MDMA_WR);
        // Generic codes need ATA select low, others high
        if (PWDATA[7:1] == 7'h00)
            cmd_ok = !config_w.ata_select;
        else if (PWDATA[7:1] == 7'h02)
            cmd_ok = config_w.ata_select &&
                     (config_w.programmed_io_timing <= `DCC_PIO_MAX);
        else if (PWDATA[7:1] == 7'h03)
            cmd_ok = config_w.ata_select &&
                     (config_w.ultra_multiword_timing != `DCC_UDMA_MODE3);
        else
            cmd_ok = config_w.ata_select;
        load_val = {PWDATA[31:24],
                    PSTRB[2] ? PWDATA[23:16] : stage[23:16],
                    PSTRB[1] ? PWDATA[15:8]  : stage[15:8],
                    PSTRB[0] ? PWDATA[7:0]   : stage[7:0]};
    end

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        next_state    = state;
        next_remain   = remain;
        next_stage    = stage;
        next_config_w = config_w;
        next_status   = status;
        next_master   = master;
        next_cmd      = cmd;
        next_validate = 1'b0;
        next_mem      = buf_mem;
        next_wr_ptr   = wr_ptr;
        next_rd_ptr   = rd_ptr;
        next_fill     = fill;
        next_eot_sync = {eot_sync[0], END_OF_TRANSFER_IN};
        next_rdy_sync = {rdy_sync[0], IORDY};
        // Software clears sticky flags by writing one
        if (wr_acc && hit(PADDR, `DCC_OFS_STATUS) && PSTRB[0])
        begin
            next_status.done      = status.done && !PWDATA[1];
            next_status.refused   = status.refused && !PWDATA[2];
            next_status.eot_ended = status.eot_ended && !PWDATA[3];
        end
        if (wr_acc && hit(PADDR, `DCC_OFS_CONFIG))
        begin
            if (PSTRB[0])
                next_config_w[7:0] = PWDATA[7:0];
            if (PSTRB[1])
                next_config_w[15:8] = PWDATA[15:8];
        end
        if (wr_acc && hit(PADDR, `DCC_OFS_CONTROL) && PSTRB[0])
            next_master = PWDATA[0];
        // Byte decrement while counting
        if (s_fire && cnt_en)
            next_remain = remain - 32'h0000_0001;
        // Low bytes only staged; high byte loads counter
        if (wr_acc && hit(PADDR, `DCC_OFS_COUNT))
        begin
            if (PSTRB[3])
                next_remain = load_val;
            else
                next_stage = load_val[23:0];
        end
        // Buffer write and read
        if (s_fire)
        begin
            next_mem[wr_ptr] = S_DATA;
            next_wr_ptr      = !wr_ptr;
        end
        if (m_fire)
            next_rd_ptr = !rd_ptr;
        next_fill = fill + {1'b0, s_fire} - {1'b0, m_fire};
        case (state)
            DCC_IDLE:
            begin
                // Command starts a set-up transfer
                if (cmd_wr && cmd_xfer)
                begin
                    if (cmd_ok)
                    begin
                        next_state         = DCC_RUN;
                        next_cmd           = PWDATA[7:0];
                        next_status.dir_in = !PWDATA[0];
                        next_status.done   = 1'b0;
                        next_status.eot_ended = 1'b0;
                    end
                    else
                        next_status.refused = 1'b1;
                end
            end
            DCC_RUN:
            begin
                if (cmd_wr && PWDATA[7:0] == `DCC_CMD_RESET)
                    next_state = DCC_IDLE;           // Abort on reset code
                else if (eot_close)
                begin
                    next_state            = DCC_IDLE;
                    next_validate         = 1'b1;
                    next_status.done      = 1'b1;
                    next_status.eot_ended = 1'b1;
                end
                else if (cnt_en && next_remain == 32'h0000_0000)
                begin
                    next_state       = DCC_IDLE;
                    next_status.done = 1'b1;
                end
            end
            default:
                next_state = DCC_IDLE;
        endcase
        next_status.busy = (next_state == DCC_RUN);
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            state    <= DCC_IDLE;
            remain   <= `DCC_COUNT_RST;
            stage    <= 24'h000000;
            config_w <= `DCC_CONFIG_RST;
            status   <= 5'h00;
            master   <= 1'b0;
            cmd      <= 8'h00;
            validate <= 1'b0;
            buf_mem  <= '{8'h00, 8'h00};
            wr_ptr   <= 1'b0;
            rd_ptr   <= 1'b0;
            fill     <= 2'h0;
            eot_sync <= 2'h0;
            rdy_sync <= 2'h0;
        end
        else
        begin
            state    <= next_state;
            remain   <= next_remain;
            stage    <= next_stage;
            config_w <= next_config_w;
            status   <= next_status;
            master   <= next_master;
            cmd      <= next_cmd;
            validate <= next_validate;
            buf_mem  <= next_mem;
            wr_ptr   <= next_wr_ptr;
            rd_ptr   <= next_rd_ptr;
            fill     <= next_fill;
            eot_sync <= next_eot_sync;
            rdy_sync <= next_rdy_sync;
        end
    end

    // Mode outputs follow the configuration word; strobe enable also needs a UDMA command
    always_comb
    begin
        VALIDATE_PKT  = validate;
        ATA_SELECT    = config_w.ata_select;
        ULTRA_TIMING  = config_w.ultra_multiword_timing;
        PIO_TIMING    = config_w.programmed_io_timing;
        STROBE_REG_EN = is_udma && (config_w.ultra_multiword_timing ==
                        `DCC_UDMA_MODE3);
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    count_load_a: assert property (@(posedge CLK) disable iff (!RSTN)
        wr_acc && hit(PADDR, `DCC_OFS_COUNT) && PSTRB[3] |=>
        remain == $past(load_val))
        else $error("count not loaded on high byte");
    partial_hold_a: assert property (@(posedge CLK) disable iff (!RSTN)
        wr_acc && hit(PADDR, `DCC_OFS_COUNT) && !PSTRB[3] && !s_fire |=>
        $stable(remain))
        else $error("partial write changed count");
    byte_dec_a: assert property (@(posedge CLK) disable iff (!RSTN)
        s_fire && cnt_en && !(wr_acc && hit(PADDR, `DCC_OFS_COUNT)) |=>
        remain == $past(remain) - 32'h0000_0001)
        else $error("count not decremented per byte");
    zero_stop_a: assert property (@(posedge CLK) disable iff (!RSTN)
        cnt_en && remain == 32'h0000_0000 |-> !S_READY)
        else $error("byte taken at zero count");
    master_count_a: assert property (@(posedge CLK) disable iff (!RSTN)
        master && state == DCC_RUN && s_fire &&
        !(wr_acc && hit(PADDR, `DCC_OFS_COUNT)) |=> remain != $past(remain))
        else $error("master mode counter stopped");
    eot_close_a: assert property (@(posedge CLK) disable iff (!RSTN)
        state == DCC_RUN && !cnt_en && status.dir_in && eot_sync[1] &&
        !cmd_wr |=> VALIDATE_PKT && state == DCC_IDLE ##1 !VALIDATE_PKT)
        else $error("end pin did not close inward transfer");
    eot_ignore_a: assert property (@(posedge CLK) disable iff (!RSTN)
        state == DCC_RUN && !status.dir_in && !cnt_en && !cmd_wr |=>
        state == DCC_RUN && !VALIDATE_PKT)
        else $error("outward transfer ended without cause");
    ready_gate_a: assert property (@(posedge CLK) disable iff (!RSTN)
        !rdy_sync[1] && !(is_udma && config_w.skip_ready) |-> !S_READY)
        else $error("byte taken without ready pin");
    ata_refuse_a: assert property (@(posedge CLK) disable iff (!RSTN)
        state == DCC_IDLE && cmd_wr && PWDATA[7:1] == 7'h00 &&
        config_w.ata_select |=> state == DCC_IDLE && status.refused)
        else $error("generic command ran in Ata_select");
endmodule : dcc_top
`default_nettype wire

// file: tb/dcc_ext_model.sv
// Purpose: External party: byte source, byte sink, end and ready pins
// Assumes: Controls from the bench change right after rising edges
// Notes:   A released data line toggles each cycle between its last byte and its inverse
`timescale 1ns/100ps
`default_nettype none
module dcc_ext_model
(
    // Clock, reset and scenario controls
    input  wire logic        CLK,
    input  wire logic        RSTN,
    input  wire logic        src_en,
    input  wire logic        sink_stall,
    input  wire logic        eot_req,
    input  wire logic        rdy_req,
    // Byte stream into the block
    input  wire logic        S_READY,
    output logic             S_VALID,
    output logic      [7:0]  S_DATA,
    // Byte stream out of the block
    input  wire logic        M_VALID,
    input  wire logic [7:0]  M_DATA,
    output logic             M_READY,
    // Pins and tallies
    output logic             END_OF_TRANSFER_IN,
    output logic             IORDY,
    output logic      [15:0] sent,
    output logic      [15:0] got
);
    // ----------------------------------------------------------------
    // Source, sink and pins
    // ----------------------------------------------------------------
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            S_VALID <= 1'b0;
            S_DATA  <= 8'hA5;
            sent    <= 16'h0000;
            got     <= 16'h0000;
        end
        else
        begin
            // Offer held until taken, then next byte or release
            if (S_VALID && S_READY)
                sent <= sent + 16'h0001;
            if (!S_VALID || S_READY)
            begin
                S_VALID <= src_en;
                S_DATA  <= src_en ? sent[7:0] + {7'h00, S_VALID}
                                  : ~S_DATA;
            end
            // Sink tally of accepted bytes
            if (M_VALID && M_READY)
                got <= got + 16'h0001;
        end
        M_READY            <= !sink_stall;
        END_OF_TRANSFER_IN <= eot_req;
        IORDY              <= rdy_req;
    end
endmodule : dcc_ext_model
`default_nettype wire

// file: tb/tb_top.sv
// Purpose: Self-checking bench of the counter and configuration block
// Assumes: APB master waits for PREADY; external party is a model
// Notes:   Expectations come from the register layout only
`include "dcc_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import dcc_pkg::*;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, pready, pslverr, er, end_of_transfer_in, iordy, vpkt;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'h0;
    logic        s_valid, s_ready, m_valid, m_ready, ata, strobe_en;
    logic        src_en = 1'b0, stall = 1'b0, eot_req = 1'b0;
    logic        rdy_req = 1'b0;
    logic [7:0]  s_data, m_data;
    logic [1:0]  ut;
    logic [2:0]  pt;
    logic [15:0] sent, got, g0;
    logic [31:0] rcfg [4] = '{32'h0001, 32'h2001, 32'h2501, 32'h3801};
    logic [7:0]  rcmd [4] = '{`DCC_CMD_UDMA_RD, `DCC_CMD_GENERIC_DMA_RD,
                              `DCC_CMD_PIO_RD, `DCC_CMD_MDMA_RD};
    int          errors = 0, compares = 0, vcnt = 0;

    always #12.5 clk = ~clk;
    // Tally of packet-validate pulses
    always @(posedge clk)
        if (vpkt === 1'b1)
            vcnt++;
    // Sink bytes leave in source order
    always @(posedge clk)
        if (m_valid === 1'b1 && m_ready === 1'b1)
            chk({24'h0, m_data}, {24'h0, got[7:0]});

    dcc_top dut (.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .END_OF_TRANSFER_IN(end_of_transfer_in), .IORDY(iordy), .S_VALID(s_valid),
        .S_DATA(s_data), .S_READY(s_ready), .M_VALID(m_valid),
        .M_DATA(m_data), .M_READY(m_ready), .VALIDATE_PKT(vpkt),
        .ATA_SELECT(ata), .ULTRA_TIMING(ut), .PIO_TIMING(pt),
        .STROBE_REG_EN(strobe_en));
    dcc_ext_model ext (.CLK(clk), .RSTN(rstn), .src_en(src_en),
        .sink_stall(stall), .eot_req(eot_req), .rdy_req(rdy_req),
        .S_READY(s_ready), .S_VALID(s_valid), .S_DATA(s_data),
        .M_VALID(m_valid), .M_DATA(m_data), .M_READY(m_ready),
        .END_OF_TRANSFER_IN(end_of_transfer_in), .IORDY(iordy), .sent(sent), .got(got));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got_v, input logic [31:0] exp);
        compares++;
        if (got_v !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got_v, exp);
        end
    endtask : chk

    // One APB transfer; data and error taken at the completing edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        logic ok;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            rd = prdata;
            er = pslverr;
            ok = pready;
        end while (ok !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF);
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(rd, exp);
    endtask : rdc

    // Count written low half first, high half last
    task automatic set_cnt(input logic [31:0] v);
        apb(1'b1, `DCC_OFS_COUNT, v, 4'h3);
        apb(1'b1, `DCC_OFS_COUNT, v, 4'hC);
    endtask : set_cnt

    // Poll busy under a bounded count
    task automatic wait_idle();
        for (int k = 0; k < 100; k++)
        begin
            apb(1'b0, `DCC_OFS_STATUS, 32'h0, 4'h0);
            if (rd[0] === 1'b0)
                return;
        end
        errors++;
    endtask : wait_idle

    function automatic logic [31:0] cfg(input logic s, input logic a,
        input logic [1:0] u, input logic [2:0] p, input logic d);
        return {16'h0000, 1'b0, s, a, u, p, d, 7'h01};
    endfunction : cfg

    // ----------------------------------------------------------------
    // Watchdog and test sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        complete_run();
    end

    initial
    begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        // Reset values, command read-back, unmapped word
        rdc(`DCC_OFS_COUNT, 32'h0);
        rdc(`DCC_OFS_CONFIG, {16'h0, `DCC_CONFIG_RST});
        rdc(`DCC_OFS_CMD, `DCC_CMD_READ);
        rdc(12'h03C, 32'h0);
        chk({31'h0, er}, 32'h1);
        // Partial writes stay staged until the high byte
        apb(1'b1, `DCC_OFS_COUNT, 32'h0000_0106, 4'h3);
        rdc(`DCC_OFS_COUNT, 32'h0);
        apb(1'b1, `DCC_OFS_COUNT, 32'h0002_0000, 4'h4);
        rdc(`DCC_OFS_COUNT, 32'h0);
        apb(1'b1, `DCC_OFS_COUNT, 32'h0, 4'h8);
        rdc(`DCC_OFS_COUNT, 32'h0002_0106);
        // Every UDMA/MDMA timing value and PIO values 0-4 reach the mode outputs
        for (int u = 0; u < 4; u++)
            for (int p = 0; p < 5; p++)
            begin
                wr(`DCC_OFS_CONFIG, cfg(1'b0, 1'b1, u[1:0], p[2:0], 1'b0));
                rdc(`DCC_OFS_CONFIG, cfg(1'b0, 1'b1, u[1:0], p[2:0], 1'b0));
                chk({26'h0, ata, ut, pt}, {26'h1, u[1:0], p[2:0]});
            end
        // Commands refused by mode mismatch
        rdy_req <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            wr(`DCC_OFS_CONFIG, rcfg[i]);
            wr(`DCC_OFS_CMD, {24'h0, rcmd[i]});
            apb(1'b0, `DCC_OFS_STATUS, 32'h0, 4'h0);
            chk(rd & 32'h7, 32'h4);
            wr(`DCC_OFS_STATUS, 32'h4);
        end
        // Counted transfer for every transfer command, codes 0-7, first one with sink stall
        src_en <= 1'b1;
        for (int c = 0; c < 8; c++)
        begin
            stall <= (c == 0);
            g0 = got;
            wr(`DCC_OFS_CONFIG, cfg(1'b0, c > 1, 2'h0, 3'h4, 1'b0));
            set_cnt(32'h3);
            wr(`DCC_OFS_CMD, 32'(c));
            if (c == 0)
            begin
                repeat (10) @(posedge clk);
                rdc(`DCC_OFS_COUNT, 32'h1);
                stall <= 1'b0;
            end
            wait_idle();
            rdc(`DCC_OFS_COUNT, 32'h0);
            repeat (4) @(posedge clk);
            chk({16'h0, got - g0}, 32'h3);
        end
        // Master mode keeps the counter despite the disable bit
        wr(`DCC_OFS_CONTROL, 32'h1);
        wr(`DCC_OFS_CONFIG, cfg(1'b0, 1'b0, 2'h0, 3'h0, 1'b1));
        set_cnt(32'h2);
        g0 = got;
        wr(`DCC_OFS_CMD, 32'h0);
        wait_idle();
        repeat (4) @(posedge clk);
        chk({16'h0, got - g0}, 32'h2);
        wr(`DCC_OFS_CONTROL, 32'h0);
        wr(`DCC_OFS_STATUS, 32'hE);
        // Slave with counter off runs past the count, end pin closes it
        g0 = got;
        wr(`DCC_OFS_CMD, 32'h0);
        repeat (12) @(posedge clk);
        chk({31'h0, (got - g0) > 16'h2}, 32'h1);
        eot_req <= 1'b1;
        wait_idle();
        chk(rd & 32'hF, 32'hA);
        chk(32'(vcnt), 32'h1);
        eot_req <= 1'b0;
        wr(`DCC_OFS_STATUS, 32'hE);
        // Outward transfer ignores the end pin
        wr(`DCC_OFS_CMD, 32'h1);
        eot_req <= 1'b1;
        repeat (8) @(posedge clk);
        apb(1'b0, `DCC_OFS_STATUS, 32'h0, 4'h0);
        chk(rd & 32'h1, 32'h1);
        chk(32'(vcnt), 32'h1);
        wr(`DCC_OFS_CMD, 32'h11);
        eot_req <= 1'b0;
        // UDMA mode 3, ready pin low, with and without skip bit
        rdy_req <= 1'b0;
        for (int k = 1; k >= 0; k--)
        begin
            wr(`DCC_OFS_CONFIG, cfg(k[0], 1'b1, 2'h3, 3'h0, 1'b0));
            set_cnt(32'h2);
            wr(`DCC_OFS_CMD, 32'h2);
            @(negedge clk);
            chk({31'h0, strobe_en}, 32'h1);
            repeat (10) @(posedge clk);
            rdc(`DCC_OFS_COUNT, (k == 1) ? 32'h0 : 32'h2);
            wr(`DCC_OFS_CMD, 32'h11);
        end
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
